// ===== hdl/swc_map.svh
/*
 * Constants of the sleep and wake-up controller: pin counts, timer slots,
 * wake delays and the slow-oscillator tick divider.
 * Assumes a 20 MHz system clock and that the includer needs no other macros.
 */
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH

// System clock period in nanoseconds (20 MHz).
`define SWC_CLK_NS        50
// Slow oscillator period in nanoseconds; a plain default, trimmed per part.
`define SWC_SLOW_NS       16000
// System clocks per slow-oscillator tick, rounded down, with no lower bound.
`define SWC_SLOW_DIV      ((`SWC_SLOW_NS) / (`SWC_CLK_NS))
// Width of the tick divider counter.
`define SWC_DIV_W         9

// Number of wake-capable I/O pins.
`define SWC_PINS          8

// Wake-up delays in slow-oscillator clocks.
`define SWC_WAKE_NORMAL   16
`define SWC_WAKE_FAST     8
`define SWC_WCNT_W        5

// Timer slots in the timer vectors.
`define SWC_TMR_T16       0
`define SWC_TMR_T2        1
`define SWC_TMR_T3        2
`define SWC_TMR_PWM       3
`define SWC_TMRS          4

// Bit positions of the latched wake cause.
`define SWC_SRC_PIN       3
`define SWC_SRC_TIMER     2
`define SWC_SRC_NANO      1
`define SWC_SRC_COMP      0

`endif

// ===== hdl/swc_pkg.sv
/*
 * Types of the sleep and wake-up controller: the mode enumeration,
 * oscillator group and the state records of both modules.
 * Assumes swc_map.svh is on the include path.
 */
`include "swc_map.svh"

package swc_pkg;

	// Operating modes of the controller.
	typedef enum logic [1:0] {
		SWC_RUN,
		SWC_LIGHT,
		SWC_DEEP,
		SWC_WAKE
	} swc_mode_t;

	// Oscillator enables, carried together.
	typedef struct packed {
		logic fast;
		logic slow;
		logic nano;
	} swc_osc_t;

	// Whole state of the controller.
	typedef struct packed {
		swc_mode_t               mode;
		logic [`SWC_PINS-1:0]    pin_ref;
		logic [`SWC_WCNT_W-1:0]  wake_cnt;
		logic                    wake_fast;
		logic [3:0]              wake_src;
		swc_osc_t                osc_en;
		logic                    core_clk_en;
		logic                    prog_mem_on;
		logic                    retain;
		logic                    resume;
		logic [`SWC_TMRS-1:0]    timer_run;
	} swc_state_t;

	// Reset image: running, memory powered, oscillators off until configured.
	localparam swc_state_t SWC_STATE_RST = '{
		mode:        SWC_RUN,
		pin_ref:     8'h00,
		wake_cnt:    5'h00,
		wake_fast:   1'b0,
		wake_src:    4'h0,
		osc_en:      3'h0,
		core_clk_en: 1'b1,
		prog_mem_on: 1'b1,
		retain:      1'b0,
		resume:      1'b0,
		timer_run:   4'hF
	};

	// State of the slow-tick divider.
	typedef struct packed {
		logic [`SWC_DIV_W-1:0] cnt;
	} swc_div_t;

endpackage

// ===== hdl/swc_tick_div.sv
/*
 * Divider that makes the slow-oscillator tick as a one-cycle enable.
 * Assumes one system clock; clear restarts the slow period from zero.
 */
`timescale 1ns/100ps
`default_nettype none
`include "swc_map.svh"

module swc_tick_div (
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	input  wire logic clear_in,
	output logic      tick_out
);

	swc_pkg::swc_div_t d_reg;
	swc_pkg::swc_div_t d_next;

	// The tick marks the last system cycle of each slow period.
	always_comb begin
		d_next = d_reg;
		tick_out = (d_reg.cnt == `SWC_DIV_W'(`SWC_SLOW_DIV - 1));
		if (clear_in || tick_out) begin
			d_next.cnt = '0;
		end else begin
			d_next.cnt = d_reg.cnt + `SWC_DIV_W'(1);
		end
	end

	// Counter register.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			d_reg <= '0;
		end else begin
			d_reg <= d_next;
		end
	end

endmodule

`default_nettype wire

// ===== hdl/swc_top.sv
/*
 * Sleep and wake-up controller: run, light sleep and deep sleep, oscillator
 * and core-clock gating, timer hold, wake qualification and wake delay.
 * Assumes all inputs are synchronous to CLK_SYS_IN, that sleep requests are
 * one-cycle pulses from instruction decode, and that match inputs are pulses.
 */
`timescale 1ns/100ps
`default_nettype none
`include "swc_map.svh"

// Notes on behaviour
// - Three modes: run, light sleep by one instruction, deep sleep by another.
// - Deep sleep stops fast and slow oscillators; nano unchanged; light forces slow on.
// - Light sleep gates the core clock and program memory; oscillators keep running.
// - In light sleep a timer halts if core-clocked or its oscillator is off.
// - Program memory is powered off in either sleep mode.
// - Deep sleep retains all SRAM and register contents.
// - Light sleep pin wake needs input direction and digital-in enable set.
// - Deep sleep wakes on toggle of any digital-in enabled pin.
// - Light sleep wakes when a non-core-clocked timer reaches its trigger.
// - Sixteen-bit timer and comparator wake only in light; deep takes pins, nano timers.
// - Eight-bit timers on nano oscillator with aux bit 0 wake either sleep.
// - Comparator wake needs comparator enable and wake select both set.
// - After wake execution continues at the instruction after sleep.
// - Wake takes 16 slow clocks normally, 8 when fast wake is selected.
// - Fast boot forces fast wake; otherwise the aux bit chooses.
// - Slow oscillator stays on through light sleep; wake timing restarts from it.
// - Sixteen-bit timer on fast osc, bit 8 trigger, wakes after 256 clocks.
module swc_top (
	input  wire logic                  CLK_SYS_IN,
	input  wire logic                  RESET_N_IN,
	input  wire logic                  LIGHT_SLEEP_REQ_IN,
	input  wire logic                  DEEP_SLEEP_REQ_IN,
	input  wire swc_pkg::swc_osc_t     OSC_CFG_IN,
	input  wire logic [`SWC_PINS-1:0]  PIN_LEVEL_IN,
	input  wire logic [`SWC_PINS-1:0]  PIN_DIRECTION_IN,
	input  wire logic [`SWC_PINS-1:0]  PIN_DIGITAL_IN_ENABLE_IN,
	input  wire logic [`SWC_TMRS-1:0]  TIMER_SRC_CORE_IN,
	input  wire logic [`SWC_TMRS-1:0]  TIMER_OSC_ON_IN,
	input  wire logic                  T16_MATCH_IN,
	input  wire logic [1:0]            TIMER8_MATCH_IN,
	input  wire logic [1:0]            TIMER8_SRC_NANO_IN,
	input  wire logic                  AUX2_NANO_EN_IN,
	input  wire logic                  COMP_EVENT_IN,
	input  wire logic                  COMP_ENABLE_IN,
	input  wire logic                  COMP_WAKE_SEL_IN,
	input  wire logic                  AUX_FAST_WAKE_IN,
	input  wire logic                  FAST_BOOT_IN,
	output logic [1:0]                 MODE_OUT,
	output swc_pkg::swc_osc_t          OSC_EN_OUT,
	output logic                       CORE_CLK_EN_OUT,
	output logic                       PROG_MEM_ON_OUT,
	output logic                       RETAIN_OUT,
	output logic                       RESUME_OUT,
	output logic [`SWC_TMRS-1:0]       TIMER_RUN_OUT,
	output logic [3:0]                 WAKE_SRC_OUT
);

	swc_pkg::swc_state_t s_reg;
	swc_pkg::swc_state_t s_next;
	logic                slow_tick;
	logic                div_clear;
	logic [`SWC_PINS-1:0] pin_toggle;
	logic                pin_wake_light;
	logic                pin_wake_deep;
	logic                nano_wake;
	logic                timer_wake_light;
	logic                comp_wake;
	logic [3:0]          src;

	// The slow period restarts on wake entry so the delay counts whole ticks.
	assign div_clear = (s_reg.mode != swc_pkg::SWC_WAKE);

	swc_tick_div u_tick (
		.clk_in     (CLK_SYS_IN),
		.reset_n_in (RESET_N_IN),
		.clear_in   (div_clear),
		.tick_out   (slow_tick)
	);

	// Wake qualification terms.
	always_comb begin
		pin_toggle = (PIN_LEVEL_IN ^ s_reg.pin_ref) & PIN_DIGITAL_IN_ENABLE_IN;
		pin_wake_light = |(pin_toggle & ~PIN_DIRECTION_IN);
		pin_wake_deep = |pin_toggle;
		nano_wake = (|(TIMER8_MATCH_IN & TIMER8_SRC_NANO_IN)) & AUX2_NANO_EN_IN;
		// Timer trigger reached; the 256-clock case arrives as T16_MATCH_IN.
		timer_wake_light = (T16_MATCH_IN & ~TIMER_SRC_CORE_IN[`SWC_TMR_T16])
			| (|(TIMER8_MATCH_IN & ~TIMER_SRC_CORE_IN[`SWC_TMR_T3:`SWC_TMR_T2]));
		comp_wake = COMP_EVENT_IN & COMP_ENABLE_IN & COMP_WAKE_SEL_IN;
	end

	// Mode sequencing and output image, all computed into the next state.
	always_comb begin
		s_next = s_reg;
		s_next.resume = 1'b0;
		src = 4'h0;
		unique case (s_reg.mode)
			swc_pkg::SWC_RUN: begin
				// Sleep entry; deep wins if both decode together.
				if (DEEP_SLEEP_REQ_IN) begin
					s_next.mode = swc_pkg::SWC_DEEP;
					s_next.pin_ref = PIN_LEVEL_IN;
				end else if (LIGHT_SLEEP_REQ_IN) begin
					s_next.mode = swc_pkg::SWC_LIGHT;
					s_next.pin_ref = PIN_LEVEL_IN;
				end
			end
			swc_pkg::SWC_LIGHT: begin
				src[`SWC_SRC_PIN] = pin_wake_light;
				src[`SWC_SRC_TIMER] = timer_wake_light;
				src[`SWC_SRC_NANO] = nano_wake;
				src[`SWC_SRC_COMP] = comp_wake;
			end
			swc_pkg::SWC_DEEP: begin
				// Deep sleep ignores sixteen_bit_timer and comparator.
				src[`SWC_SRC_PIN] = pin_wake_deep;
				src[`SWC_SRC_NANO] = nano_wake;
			end
			swc_pkg::SWC_WAKE: begin
				// Count slow ticks to 8 or 16.
				if (slow_tick) begin
					if (s_reg.wake_cnt == (s_reg.wake_fast ?
						`SWC_WCNT_W'(`SWC_WAKE_FAST - 1) :
						`SWC_WCNT_W'(`SWC_WAKE_NORMAL - 1))) begin
						s_next.mode = swc_pkg::SWC_RUN;
						s_next.resume = 1'b1;
						s_next.wake_cnt = '0;
					end else begin
						s_next.wake_cnt = s_reg.wake_cnt + `SWC_WCNT_W'(1);
					end
				end
			end
		endcase
		if (|src) begin
			s_next.mode = swc_pkg::SWC_WAKE;
			s_next.wake_src = src;
			s_next.wake_cnt = '0;
			s_next.wake_fast = FAST_BOOT_IN | AUX_FAST_WAKE_IN;
		end
		s_next.core_clk_en = (s_next.mode == swc_pkg::SWC_RUN);
		s_next.prog_mem_on = (s_next.mode == swc_pkg::SWC_RUN)
			|| (s_next.mode == swc_pkg::SWC_WAKE);
		// Freeze SRAM and registers in deep sleep.
		s_next.retain = (s_next.mode == swc_pkg::SWC_DEEP);
		// Deep sleep stops fast and slow; nano follows its setting.
		s_next.osc_en.fast = OSC_CFG_IN.fast && (s_next.mode != swc_pkg::SWC_DEEP);
		// Slow oscillator held on through light sleep and wake.
		s_next.osc_en.slow = (OSC_CFG_IN.slow && (s_next.mode != swc_pkg::SWC_DEEP))
			|| (s_next.mode == swc_pkg::SWC_LIGHT) || (s_next.mode == swc_pkg::SWC_WAKE);
		s_next.osc_en.nano = OSC_CFG_IN.nano;
		unique case (s_next.mode)
			swc_pkg::SWC_RUN: s_next.timer_run = 4'hF;
			swc_pkg::SWC_DEEP: begin
				s_next.timer_run = 4'h0;
				s_next.timer_run[`SWC_TMR_T3:`SWC_TMR_T2] =
					TIMER8_SRC_NANO_IN & {2{AUX2_NANO_EN_IN}};
			end
			default: s_next.timer_run = ~TIMER_SRC_CORE_IN & TIMER_OSC_ON_IN;
		endcase
	end

	// State register.
	always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			s_reg <= swc_pkg::SWC_STATE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register.
	assign MODE_OUT        = s_reg.mode;
	assign OSC_EN_OUT      = s_reg.osc_en;
	assign CORE_CLK_EN_OUT = s_reg.core_clk_en;
	assign PROG_MEM_ON_OUT = s_reg.prog_mem_on;
	assign RETAIN_OUT      = s_reg.retain;
	assign RESUME_OUT      = s_reg.resume;
	assign TIMER_RUN_OUT   = s_reg.timer_run;
	assign WAKE_SRC_OUT    = s_reg.wake_src;

	// Cycles spent in wake, read only by the delay check.
	logic [12:0] wake_cycles_reg;
	localparam int FAST_LAST = `SWC_WAKE_FAST * `SWC_SLOW_DIV - 1;
	localparam int NORM_LAST = `SWC_WAKE_NORMAL * `SWC_SLOW_DIV - 1;
	always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			wake_cycles_reg <= 13'h0000;
		end else if (s_reg.mode == swc_pkg::SWC_WAKE) begin
			wake_cycles_reg <= wake_cycles_reg + 13'h0001;
		end else begin
			wake_cycles_reg <= 13'h0000;
		end
	end

	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RESET_N_IN);

	sequence seq_enter_wake;
		(s_reg.mode != swc_pkg::SWC_WAKE) ##1 (s_reg.mode == swc_pkg::SWC_WAKE);
	endsequence

	sequence seq_leave_wake;
		(s_reg.mode == swc_pkg::SWC_WAKE) ##1 (s_reg.mode == swc_pkg::SWC_RUN);
	endsequence

	chk_light_entry: assert property (
		(s_reg.mode == swc_pkg::SWC_RUN && LIGHT_SLEEP_REQ_IN && !DEEP_SLEEP_REQ_IN)
		|=> (MODE_OUT == swc_pkg::SWC_LIGHT && !CORE_CLK_EN_OUT && !PROG_MEM_ON_OUT
		&& OSC_EN_OUT.fast == $past(OSC_CFG_IN.fast)))
		else $error("light sleep entry wrong");

	chk_deep_osc: assert property (
		(s_reg.mode == swc_pkg::SWC_RUN && DEEP_SLEEP_REQ_IN)
		|=> (!OSC_EN_OUT.fast && !OSC_EN_OUT.slow && RETAIN_OUT
		&& OSC_EN_OUT.nano == $past(OSC_CFG_IN.nano)))
		else $error("deep sleep oscillator gating wrong");

	chk_slow_held: assert property (
		(MODE_OUT == swc_pkg::SWC_LIGHT || MODE_OUT == swc_pkg::SWC_WAKE) |-> OSC_EN_OUT.slow)
		else $error("slow oscillator dropped while asleep");

	chk_timer_halt: assert property (
		(s_next.mode == swc_pkg::SWC_LIGHT && TIMER_SRC_CORE_IN[`SWC_TMR_T16])
		|=> !TIMER_RUN_OUT[`SWC_TMR_T16])
		else $error("core-clocked timer kept running in light sleep");

	chk_pin_light: assert property (
		(s_reg.mode == swc_pkg::SWC_LIGHT && pin_wake_light)
		|=> (MODE_OUT == swc_pkg::SWC_WAKE && WAKE_SRC_OUT[`SWC_SRC_PIN]))
		else $error("enabled input pin toggle did not wake");

	chk_deep_only: assert property (
		(s_reg.mode == swc_pkg::SWC_DEEP && !pin_wake_deep && !nano_wake)
		|=> MODE_OUT == swc_pkg::SWC_DEEP)
		else $error("deep sleep woke on a light-only source");

	chk_nano_deep: assert property (
		(s_reg.mode == swc_pkg::SWC_DEEP && nano_wake)
		|=> (MODE_OUT == swc_pkg::SWC_WAKE && WAKE_SRC_OUT[`SWC_SRC_NANO]))
		else $error("nano-clocked timer did not wake deep sleep");

	chk_wake_time: assert property (
		(s_reg.mode == swc_pkg::SWC_WAKE && s_next.mode == swc_pkg::SWC_RUN)
		|-> (wake_cycles_reg == (s_reg.wake_fast ? 13'(FAST_LAST) : 13'(NORM_LAST))))
		else $error("wake delay length wrong");

	chk_fast_boot: assert property (
		seq_enter_wake |-> (s_reg.wake_fast == ($past(FAST_BOOT_IN) || $past(AUX_FAST_WAKE_IN))))
		else $error("wake speed selection wrong");

	chk_resume: assert property (
		seq_leave_wake |-> (RESUME_OUT && CORE_CLK_EN_OUT && PROG_MEM_ON_OUT) ##1 !RESUME_OUT)
		else $error("resume after wake wrong");

	chk_timer_wake: assert property (
		(s_reg.mode == swc_pkg::SWC_LIGHT && T16_MATCH_IN && !TIMER_SRC_CORE_IN[`SWC_TMR_T16])
		|=> (MODE_OUT == swc_pkg::SWC_WAKE && WAKE_SRC_OUT[`SWC_SRC_TIMER]))
		else $error("free-running timer did not wake light sleep");

	chk_comp_wake: assert property (
		(s_reg.mode == swc_pkg::SWC_LIGHT && COMP_EVENT_IN && COMP_ENABLE_IN && COMP_WAKE_SEL_IN)
		|=> (MODE_OUT == swc_pkg::SWC_WAKE && WAKE_SRC_OUT[`SWC_SRC_COMP]))
		else $error("enabled comparator did not wake light sleep");

	chk_comp_gated: assert property (
		(s_reg.mode == swc_pkg::SWC_LIGHT && COMP_EVENT_IN && !(COMP_ENABLE_IN && COMP_WAKE_SEL_IN))
		|=> !(MODE_OUT == swc_pkg::SWC_WAKE && WAKE_SRC_OUT[`SWC_SRC_COMP]))
		else $error("comparator woke light sleep without both enables");

	chk_sleep_power: assert property (
		(MODE_OUT == swc_pkg::SWC_LIGHT || MODE_OUT == swc_pkg::SWC_DEEP)
		|-> (!PROG_MEM_ON_OUT && !CORE_CLK_EN_OUT))
		else $error("program memory or core clock on while asleep");

	chk_deep_retain: assert property (
		RETAIN_OUT == (MODE_OUT == swc_pkg::SWC_DEEP))
		else $error("retention not matching deep sleep");

endmodule

`default_nettype wire

// ===== dv/swc_pin_model.sv
/*
 * Outside circuitry on the wake-capable pins: holds each pin level and flips
 * the pins that the bench names.
 * Assumes the caller toggles from a falling edge; the flip lands on the next one.
 */
`timescale 1ns/100ps
`default_nettype none
`include "swc_map.svh"

module swc_pin_model (
	input  wire logic                 clk_in,
	output logic [`SWC_PINS-1:0]      pin_level_out
);

	// Pins start low; an undriven pin would hide a missed latch at sleep entry.
	initial begin
		pin_level_out = 8'h00;
	end

	// A toggle is a clean level change that stays until toggled again.
	task automatic toggle(input logic [`SWC_PINS-1:0] mask);
		@(negedge clk_in);
		pin_level_out = pin_level_out ^ mask;
	endtask

endmodule

`default_nettype wire

// ===== dv/sleep_wakeup_control_bench.sv
/*
 * Self-checking bench of the sleep and wake-up controller: sleep entry,
 * wake qualification per mode, wake delays and the resume pulse.
 * Assumes swc_map.svh and swc_pkg, and the pin model beside it.
 */
`timescale 1ns/100ps
`default_nettype none
`include "swc_map.svh"

module sleep_wakeup_control_bench;

	logic              clk, rst_n, light_req, deep_req, t16_match, aux2_nano;
	logic              comp_ev, comp_en, comp_sel, aux_fast, fast_boot;
	logic              core_en, mem_on, retain, resume;
	logic [7:0]        pins, pin_dir, pin_die;
	logic [3:0]        tmr_core, tmr_osc, tmr_run, wake_src;
	logic [1:0]        t8_match, t8_nano, mode;
	swc_pkg::swc_osc_t osc_cfg, osc_en;
	int                error_cnt, checks_done;

	swc_pin_model pin_model (.clk_in(clk), .pin_level_out(pins));

	swc_top dut (
		.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .LIGHT_SLEEP_REQ_IN(light_req),
		.DEEP_SLEEP_REQ_IN(deep_req), .OSC_CFG_IN(osc_cfg), .PIN_LEVEL_IN(pins),
		.PIN_DIRECTION_IN(pin_dir), .PIN_DIGITAL_IN_ENABLE_IN(pin_die),
		.TIMER_SRC_CORE_IN(tmr_core), .TIMER_OSC_ON_IN(tmr_osc), .T16_MATCH_IN(t16_match),
		.TIMER8_MATCH_IN(t8_match), .TIMER8_SRC_NANO_IN(t8_nano), .AUX2_NANO_EN_IN(aux2_nano),
		.COMP_EVENT_IN(comp_ev), .COMP_ENABLE_IN(comp_en), .COMP_WAKE_SEL_IN(comp_sel),
		.AUX_FAST_WAKE_IN(aux_fast), .FAST_BOOT_IN(fast_boot), .MODE_OUT(mode),
		.OSC_EN_OUT(osc_en), .CORE_CLK_EN_OUT(core_en), .PROG_MEM_ON_OUT(mem_on),
		.RETAIN_OUT(retain), .RESUME_OUT(resume), .TIMER_RUN_OUT(tmr_run),
		.WAKE_SRC_OUT(wake_src)
	);

	// A 50 ns period gives the 20 MHz system clock.
	always #25 clk = ~clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	// Requests are one-cycle pulses, launched and dropped at falling edges.
	task automatic sleep(input logic deep);
		deep_req = deep;
		light_req = ~deep;
		cyc(1);
		deep_req = 1'b0;
		light_req = 1'b0;
	endtask

	// One-cycle event pulse on {t16 match, comparator, timer2 match}.
	task automatic kick(input logic [2:0] k);
		{t16_match, comp_ev, t8_match[0]} = k;
		cyc(1);
		{t16_match, comp_ev, t8_match[0]} = 3'h0;
	endtask

	// Waits for the wake phase, measures its length and the resume pulse after it.
	task automatic wake_len(input int exp_len);
		int n;
		n = 0;
		while (mode !== 2'h3 && n < 4) begin
			cyc(1);
			n++;
		end
		check(16'(mode), 16'h0003);
		check(16'(mem_on), 16'h0001);
		n = 0;
		while (mode === 2'h3 && n < 6000) begin
			cyc(1);
			n++;
		end
		check(16'(n), 16'(exp_len));
		check(16'(resume), 16'h0001);
		cyc(1);
		check(16'(resume), 16'h0000);
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// A hang is cut off well past the roughly 21000 cycles the tests need.
	initial begin
		#2_000_000;
		error_cnt++;
		summarize();
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{light_req, deep_req, t16_match, comp_ev, comp_en, comp_sel} = 6'h00;
		{aux2_nano, aux_fast, fast_boot, t8_match, t8_nano} = 7'h00;
		osc_cfg = 3'h5;
		pin_dir = 8'hFF;
		pin_die = 8'h00;
		tmr_core = 4'h1;
		tmr_osc = 4'hB;
		error_cnt = 0;
		checks_done = 0;
		cyc(6);
		check(16'({mode, core_en, mem_on, retain, resume}), 16'h000C);
		check(16'({tmr_run, wake_src}), 16'h00F0);
		rst_n = 1'b1;
		cyc(1);
		check(16'(osc_en), 16'h0005);
		done("reset");
		// Light entry gates the core clock and program memory; a second request is ignored.
		// Software keeps the watchdog off across light sleep; none is modelled.
		sleep(1'b0);
		cyc(1);
		sleep(1'b1);
		check(16'(mode), 16'h0001);
		check(16'({core_en, mem_on}), 16'h0000);
		check(16'(osc_en), 16'h0007);
		check(16'(tmr_run), 16'h000A);
		// An output pin, or one without digital input, must not wake light sleep.
		pin_model.toggle(8'h01);
		cyc(4);
		check(16'(mode), 16'h0001);
		pin_die = 8'h01;
		cyc(4);
		check(16'(mode), 16'h0001);
		// Wake pin set to input with digital input on.
		pin_dir = 8'hFE;
		wake_len(16 * `SWC_SLOW_DIV);
		check(16'(wake_src), 16'h0008);
		done("light_pin");
		// A core-clocked sixteen-bit timer may not wake; a free-running one may.
		sleep(1'b0);
		kick(3'h4);
		cyc(3);
		check(16'(mode), 16'h0001);
		tmr_core = 4'h0;
		aux_fast = 1'b1;
		kick(3'h4);
		wake_len(8 * `SWC_SLOW_DIV);
		check(16'(wake_src), 16'h0004);
		aux_fast = 1'b0;
		done("light_timer");
		// The comparator needs both its enable and its wake select.
		sleep(1'b0);
		comp_en = 1'b1;
		kick(3'h2);
		cyc(3);
		check(16'(mode), 16'h0001);
		comp_sel = 1'b1;
		fast_boot = 1'b1;
		kick(3'h2);
		wake_len(8 * `SWC_SLOW_DIV);
		check(16'(wake_src), 16'h0001);
		fast_boot = 1'b0;
		comp_en = 1'b0;
		done("light_comp");
		sleep(1'b1);
		check(16'(mode), 16'h0002);
		check(16'(osc_en), 16'h0001);
		check(16'({retain, mem_on, core_en}), 16'h0004);
		// Deep sleep ignores the timer, comparator and a nano timer without aux enable.
		comp_en = 1'b1;
		t8_nano = 2'h1;
		kick(3'h7);
		cyc(3);
		check(16'(mode), 16'h0002);
		comp_en = 1'b0;
		// A digitally enabled pin wakes deep sleep even when set as an output.
		pin_die = 8'h03;
		pin_model.toggle(8'h02);
		wake_len(16 * `SWC_SLOW_DIV);
		check(16'(wake_src), 16'h0008);
		done("deep_pin");
		sleep(1'b1);
		aux2_nano = 1'b1;
		kick(3'h1);
		wake_len(16 * `SWC_SLOW_DIV);
		check(16'(wake_src), 16'h0002);
		done("deep_nano");
		summarize();
	end

endmodule

`default_nettype wire
